// file: hdl/slg_params.svh
// Purpose: Register offsets, field positions, reset values and timing for the pulse/status input logger.
// Assumes: 40 MHz clock, APB byte addresses, one 32-bit word per register.
// Notes:   Inversion and time-on field positions of the two status channels step by two bits per channel; rise alarm bits by one.
`ifndef SLG_PARAMS_SVH
`define SLG_PARAMS_SVH
`define SLG_CLK_HZ     40000000
`define SLG_TICK_SEC   1
`define SLG_A_CTRL     8'h00
`define SLG_A_PERIOD   8'h04
`define SLG_A_THR      8'h08
`define SLG_A_STAT     8'h0C
`define SLG_A_NET      8'h10
`define SLG_A_LONG     8'h14
`define SLG_A_SHORT    8'h18
`define SLG_A_SDP      8'h1C
`define SLG_B_EN       0
`define SLG_B_COMB     1
`define SLG_B_PIT      2
`define SLG_B_STAT     4
`define SLG_B_TON      6
`define SLG_B_INV      7
`define SLG_B_RISE     10
`define SLG_RST_CTRL   32'h0000_0000
`define SLG_RST_PERIOD 16'h012C
`define SLG_RST_THR    32'h0000_0000
`endif

// file: hdl/slg_pkg.sv
// Purpose: Types shared by the pulse/status input logger.
// Assumes: Widths of the flow datapoint are fixed here.
// Notes:   State codes are one-hot.
package slg_pkg;
	typedef enum logic [3:0] {
		SLG_IDLE = 4'h1,
		SLG_RUN  = 4'h2,
		SLG_WAIT = 4'h4,
		SLG_FILL = 4'h8
	} slg_state_t;

	typedef enum logic [1:0] {
		SLG_PCOUNT = 2'h0,
		SLG_PEVENT = 2'h1,
		SLG_PMIN   = 2'h2,
		SLG_PMAX   = 2'h3
	} slg_pit_t;

	typedef struct packed {
		logic signed [15:0] net;
		logic [23:0]        long_iv;
		logic [23:0]        short_iv;
	} slg_flow_dp_t;
endpackage

// file: hdl/slg_pulse_timer.sv
// Purpose: Samples one input pin every clock, marks rising edges and times the gap between them.
// Assumes: Pin is synchronous to the clock.
// Notes:   The gap counter saturates, so very slow pulses report the ceiling value.
module slg_pulse_timer import slg_pkg::*; #(
	parameter int IVW = 24
) (
	input  wire logic           i_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_pin,
	output logic                o_lvl,
	output logic                o_pulse,
	output logic [IVW-1:0]      o_iv
);
	logic           lvl_q;
	logic           pulse_q;
	logic [IVW-1:0] age_q;
	logic [IVW-1:0] iv_q;
	logic           edge_w;

	assign edge_w = i_pin & ~lvl_q;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			lvl_q   <= 1'b0;
			pulse_q <= 1'b0;
		end else begin
			lvl_q   <= i_pin;
			pulse_q <= edge_w;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			age_q <= '0;
			iv_q  <= '0;
		end else if (edge_w) begin
			age_q <= '0;
			iv_q  <= (age_q == '1) ? age_q : IVW'(age_q + 1'b1);
		end else if (age_q != '1) begin
			age_q <= IVW'(age_q + 1'b1);
		end
	end

	assign o_lvl   = lvl_q;
	assign o_pulse = pulse_q;
	assign o_iv    = iv_q;

	sample_edge_a: assert property (@(posedge i_clk) disable iff (!i_rstn) $rose(lvl_q) |-> pulse_q)
		else $error("Rising pin edge not marked as a pulse.");
endmodule

// file: hdl/slg_status_chan.sv
// Purpose: One status channel: level or time-on datapoint per log period, with inversion and alarm.
// Assumes: The tick is one cycle per second and the period end is one cycle long.
// Notes:   The alarm is judged on the logged value, after inversion.
module slg_status_chan import slg_pkg::*; (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_lvl,
	input  wire logic        i_inv,
	input  wire logic        i_ton,
	input  wire logic        i_rise,
	input  wire logic [15:0] i_thr,
	input  wire logic        i_tick,
	input  wire logic        i_pend,
	input  wire logic [15:0] i_period,
	output logic [15:0]      o_dp,
	output logic             o_alarm
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_nx;
	logic [15:0] dp_q;
	logic [15:0] dpv;
	logic        alarm_q;
	logic        sel;
	logic        inc;

	assign sel    = i_lvl ^ i_inv;
	assign inc    = i_tick & sel & (cnt_q != 16'hFFFF);
	assign cnt_nx = 16'(cnt_q + {15'h0000, inc});

	always_comb begin
		if (i_ton) begin
			dpv = (cnt_nx > i_period) ? i_period : cnt_nx;
		end else begin
			dpv = {15'h0000, sel};
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_q <= 16'h0000;
		end else if (i_pend) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_nx;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			dp_q    <= 16'h0000;
			alarm_q <= 1'b0;
		end else if (i_pend) begin
			dp_q    <= dpv;
			alarm_q <= i_rise ? (dpv == 16'h0001) : (dpv > i_thr);
		end
	end

	assign o_dp    = dp_q;
	assign o_alarm = alarm_q;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	ton_clear_a: assert property (i_pend |=> cnt_q == 16'h0000)
		else $error("Time-on counter not cleared at datapoint.");
	ton_cap_a: assert property (i_pend && i_ton |=> o_dp <= $past(i_period))
		else $error("Time-on datapoint exceeds log period.");
	level_range_a: assert property (i_pend && !i_ton |=> o_dp <= 16'h0001)
		else $error("Level datapoint out of range.");
	level_inv_a: assert property (i_pend && !i_ton |=> o_dp[0] == $past(i_lvl ^ i_inv))
		else $error("Level datapoint does not follow inversion.");
	rise_alarm_a: assert property (i_pend && i_rise && !i_ton |=> o_alarm == o_dp[0])
		else $error("Rising level alarm does not follow logged level.");
endmodule

// file: hdl/slg_top.sv
// Purpose: Pulse and status input logger with APB registers.
// Assumes: Pins are synchronous to i_clk; APB master holds requests until pready.
// Notes:   One wait state on every APB access.
//
// How it works
// - Forward and reverse pulse trains combine into one net flow datapoint.
// - One global combine bit; off means forward and reverse pulse pins.
// - Pins sampled every clock; pulses counted and pulse gaps timed.
// - No pulse in a period outside count mode: wait for next pulse, then backfill skipped datapoints.
// - Periods with pulses log their count including every extra pulse; one ending at or during backfill logs a fill datapoint instead.
// - Backfilled datapoints carry equal minimum and maximum values.
// - Minimum flow comes from the longest pulse gap in the period.
// - Maximum flow comes from the shortest pulse gap in the period.
// - Each status pin has a normal and an inverted channel form.
// - Alarms judge the logged value after inversion.
// - Raw pin state is readable before any inversion.
// - Level recording logs 0 or 1, closed reads as 1.
// - Rising level alarm follows the logged level up and down.
// - Time-on recording counts seconds at level 1 per datapoint.
// - Time-on counter clears whenever a datapoint is made.
// - Inverted time-on counts seconds at level 0 instead.
// - Each connector pin is a flow pin or a status pin.
// - Sampled level is logged as read, or complemented when inverted.
// - Status triggers are judged at log period boundaries.
// - Time-on datapoint never exceeds the log period in seconds.
// - Level data stays within 0 to 1, so above-1 never fires.
//
// Our own choices: the APB interface to the registers and the register addresses.
`include "slg_params.svh"
module slg_top import slg_pkg::*; #(
	parameter int TICK_CYCLES = `SLG_CLK_HZ * `SLG_TICK_SEC,
	parameter int IVW         = 24
) (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic [1:0]  i_pin,
	output slg_flow_dp_t     o_flow_dp,
	output logic             o_flow_valid,
	output logic [1:0]       o_alarm
);

	localparam int TW = $clog2(TICK_CYCLES + 1);

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q;
	logic [15:0] period_q;
	logic [31:0] thr_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] rd_d;
	logic        hit;
	logic        acc;
	logic        wr;

	logic        en;
	logic        comb;
	slg_pit_t    pit;
	logic [1:0]  is_stat;

	logic [1:0]     lvl;
	logic [1:0]     pls;
	logic [IVW-1:0] iv [2];
	logic [15:0]    sdp [2];

	slg_state_t   st_q;
	slg_flow_dp_t dp_q;
	logic         valid_q;

	assign acc = i_psel & i_penable & ~pready_q;
	assign wr  = i_psel & i_penable & pready_q & i_pwrite;

	assign en      = ctrl_q[`SLG_B_EN];
	assign comb    = ctrl_q[`SLG_B_COMB];
	assign pit     = slg_pit_t'(ctrl_q[`SLG_B_PIT +: 2]);
	assign is_stat = ctrl_q[`SLG_B_STAT +: 2];

	always_comb begin
		hit  = 1'b1;
		rd_d = 32'h0000_0000;
		unique case (i_paddr)
			`SLG_A_CTRL:   rd_d = ctrl_q;
			`SLG_A_PERIOD: rd_d = {16'h0000, period_q};
			`SLG_A_THR:    rd_d = thr_q;
			`SLG_A_STAT:   rd_d = {24'h0000_00, st_q, o_alarm, lvl};
			`SLG_A_NET:    rd_d = {{16{dp_q.net[15]}}, dp_q.net};
			`SLG_A_LONG:   rd_d = {8'h00, dp_q.long_iv};
			`SLG_A_SHORT:  rd_d = {8'h00, dp_q.short_iv};
			`SLG_A_SDP:    rd_d = {sdp[1], sdp[0]};
			default:       hit  = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= acc;
			pslverr_q <= acc & ~hit;
			if (acc && !i_pwrite) begin
				prdata_q <= rd_d;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ctrl_q   <= `SLG_RST_CTRL;
			period_q <= `SLG_RST_PERIOD;
			thr_q    <= `SLG_RST_THR;
		end else if (wr) begin
			if (i_paddr == `SLG_A_CTRL) begin
				ctrl_q <= i_pwdata;
			end
			if (i_paddr == `SLG_A_PERIOD) begin
				period_q <= i_pwdata[15:0];
			end
			if (i_paddr == `SLG_A_THR) begin
				thr_q <= i_pwdata;
			end
		end
	end

	assign o_prdata  = prdata_q;
	assign o_pready  = pready_q;
	assign o_pslverr = pslverr_q;

	// ----------------------------------------------------------------
	// Seconds tick and log period
	// ----------------------------------------------------------------
	logic [TW-1:0] tcnt_q;
	logic [15:0]   secs_q;
	logic          tick;
	logic          pend;

	assign tick = (tcnt_q == TW'(TICK_CYCLES - 1));
	// A period of zero is treated as one second so boundaries never stop.
	assign pend = tick & (32'(secs_q) + 32'd1 >= 32'(period_q));

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tcnt_q <= '0;
		end else begin
			tcnt_q <= tick ? '0 : TW'(tcnt_q + 1'b1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			secs_q <= 16'h0000;
		end else if (pend) begin
			secs_q <= 16'h0000;
		end else if (tick) begin
			secs_q <= 16'(secs_q + 16'h0001);
		end
	end

	// ----------------------------------------------------------------
	// Pin sampling and status channels
	// ----------------------------------------------------------------
	logic [1:0] alarm;

	for (genvar g = 0; g < 2; g++) begin : g_pin
		slg_pulse_timer #(
			.IVW (IVW)
		) u_tmr (
			.i_clk   (i_clk),
			.i_rstn  (i_rstn),
			.i_pin   (i_pin[g]),
			.o_lvl   (lvl[g]),
			.o_pulse (pls[g]),
			.o_iv    (iv[g])
		);
		slg_status_chan u_stat (
			.i_clk    (i_clk),
			.i_rstn   (i_rstn),
			.i_lvl    (lvl[g]),
			.i_inv    (ctrl_q[`SLG_B_INV + 2*g]),
			.i_ton    (ctrl_q[`SLG_B_TON + 2*g]),
			.i_rise   (ctrl_q[`SLG_B_RISE + g]),
			.i_thr    (thr_q[16*g +: 16]),
			.i_tick   (tick),
			.i_pend   (pend & en & is_stat[g]),
			.i_period (period_q),
			.o_dp     (sdp[g]),
			.o_alarm  (alarm[g])
		);
	end

	assign o_alarm = alarm;

	// ----------------------------------------------------------------
	// Flow events
	// ----------------------------------------------------------------
	logic           fwd_ev;
	logic           rev_ev;
	logic           ev;
	logic [IVW-1:0] ev_iv;

	// In combined mode pin 1 is a direction level, high meaning reverse.
	always_comb begin
		if (comb) begin
			fwd_ev = en & ~is_stat[0] & pls[0] & ~(lvl[1] & ~is_stat[1]);
			rev_ev = en & ~is_stat[0] & pls[0] & lvl[1] & ~is_stat[1];
		end else begin
			fwd_ev = en & ~is_stat[0] & pls[0];
			rev_ev = en & ~is_stat[1] & pls[1];
		end
	end

	assign ev    = fwd_ev | rev_ev;
	assign ev_iv = (fwd_ev || comb) ? iv[0] : iv[1];

	// ----------------------------------------------------------------
	// Per-period accumulation
	// ----------------------------------------------------------------
	logic signed [15:0] cnt_q;
	logic signed [15:0] cnt_d;
	logic [15:0]        npul_q;
	logic [15:0]        npul_d;
	logic [IVW-1:0]     long_q;
	logic [IVW-1:0]     long_d;
	logic [IVW-1:0]     short_q;
	logic [IVW-1:0]     short_d;

	assign cnt_d   = 16'(cnt_q + {15'h0000, fwd_ev} - {15'h0000, rev_ev});
	assign npul_d  = (ev && npul_q != 16'hFFFF) ? 16'(npul_q + 16'h0001) : npul_q;
	assign long_d  = (ev && ev_iv > long_q) ? ev_iv : long_q;
	assign short_d = (ev && ev_iv < short_q) ? ev_iv : short_q;

	always_ff @(posedge i_clk) begin
		if (!i_rstn || pend) begin
			cnt_q   <= 16'h0000;
			npul_q  <= 16'h0000;
			long_q  <= '0;
			short_q <= '1;
		end else begin
			cnt_q   <= cnt_d;
			npul_q  <= npul_d;
			long_q  <= long_d;
			short_q <= short_d;
		end
	end

	// ----------------------------------------------------------------
	// Datapoint sequencer with backfill
	// ----------------------------------------------------------------
	logic [15:0]    skip_q;
	logic [15:0]    skip_fill;
	logic [IVW-1:0] gap_q;

	// A boundary that falls during backfill adds one more datapoint to fill,
	// trading that period's own count for an unbroken datapoint series.
	assign skip_fill = 16'(skip_q - 16'h0001 + {15'h0000, pend});

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			st_q    <= SLG_IDLE;
			skip_q  <= 16'h0000;
			gap_q   <= '0;
			dp_q    <= '0;
			valid_q <= 1'b0;
		end else begin
			valid_q <= 1'b0;
			unique case (st_q)
				SLG_IDLE: begin
					if (en) begin
						st_q <= SLG_RUN;
					end
				end
				SLG_RUN: begin
					if (!en) begin
						st_q <= SLG_IDLE;
					end else if (pend) begin
						if (pit != SLG_PCOUNT && npul_d == 16'h0000) begin
							st_q   <= SLG_WAIT;
							skip_q <= 16'h0001;
						end else begin
							dp_q    <= '{net: cnt_d, long_iv: long_d, short_iv: short_d};
							valid_q <= 1'b1;
						end
					end
				end
				SLG_WAIT: begin
					if (!en) begin
						st_q <= SLG_IDLE;
					end else if (ev) begin
						gap_q  <= ev_iv;
						st_q   <= SLG_FILL;
						skip_q <= 16'(skip_q + {15'h0000, pend});
					end else if (pend) begin
						skip_q <= 16'(skip_q + 16'h0001);
					end
				end
				SLG_FILL: begin
					dp_q    <= '{net: 16'h0000, long_iv: gap_q, short_iv: gap_q};
					valid_q <= 1'b1;
					skip_q  <= skip_fill;
					if (skip_fill == 16'h0000) begin
						st_q <= SLG_RUN;
					end
				end
			endcase
		end
	end

	assign o_flow_dp    = dp_q;
	assign o_flow_valid = valid_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_fill_start;
		st_q == SLG_WAIT && en && ev ##1 st_q == SLG_FILL;
	endsequence

	wait_exit_a: assert property (st_q == SLG_WAIT && en && ev |=> st_q == SLG_FILL)
		else $error("Waiting state did not leave on the next pulse.");
	fill_first_a: assert property (s_fill_start |=> o_flow_valid && o_flow_dp.long_iv == $past(ev_iv, 2))
		else $error("Backfill did not start with the pulse gap.");
	fill_equal_a: assert property (st_q == SLG_FILL |=> o_flow_valid && o_flow_dp.long_iv == o_flow_dp.short_iv)
		else $error("Backfill datapoint has unequal extremes.");
	empty_wait_a: assert property (st_q == SLG_RUN && en && pend && pit != SLG_PCOUNT && npul_d == 16'h0000
		|=> st_q == SLG_WAIT && !o_flow_valid)
		else $error("Empty period did not enter the waiting state.");
	net_count_a: assert property (st_q == SLG_RUN && en && pend && pit == SLG_PCOUNT
		|=> o_flow_valid && o_flow_dp.net == $past(cnt_d))
		else $error("Net flow datapoint does not match pulse count.");
	short_gap_a: assert property (ev && !pend |=> short_q <= $past(ev_iv))
		else $error("Shortest gap not tracked.");
	long_gap_a: assert property (ev && !pend |=> long_q >= $past(ev_iv))
		else $error("Longest gap not tracked.");
	comb_dir_a: assert property (en && comb && !is_stat[0] && !is_stat[1] && pls[0] |-> rev_ev == lvl[1])
		else $error("Direction level not applied in combined mode.");
endmodule

// file: tb/slg_meter.sv
// Purpose: Meter and switch contact model that drives the two connector pins.
// Assumes: Pins change just after a rising clock edge, as a synchronous source would.
// Notes:   A closed contact reads as 1; the pins are always driven, never left floating.
module slg_meter (
	input  wire logic       i_clk,
	output logic      [1:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial o_pin = 2'b00;

	// --------------------------------------------------------------
	// Pulse and contact actions
	// --------------------------------------------------------------
	// One meter pulse: closed for one cycle, then open until the next rise is due.
	// A gap below two would leave no open cycle, so no edge would be seen.
	task automatic pulse(input int p, input int gap);
		o_pin[p] <= 1'b1;
		@(posedge i_clk);
		o_pin[p] <= 1'b0;
		repeat (gap - 1) @(posedge i_clk);
	endtask

	// A contact stays where it is put until the next change.
	task automatic set_lvl(input logic [1:0] v);
		o_pin <= v;
	endtask
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench for the pulse and status input logger.
// Assumes: A tick of 10 clocks stands in for one second to keep the run short.
// Notes:   Flow pulses and contact levels come from the meter model.
`include "slg_params.svh"
module testbench import slg_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int TICK = 10;
	logic         clk, rstn, psel, penable, pwrite;
	logic [7:0]   paddr;
	logic [31:0]  pwdata, prdata, q, rng;
	logic         pready, pslverr, flow_valid, e;
	logic [1:0]   pin, alarm;
	slg_flow_dp_t flow_dp;
	int           fails, checks;
	int           exp_q[$];

	slg_top #(.TICK_CYCLES(TICK)) u_slg_top (.i_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_pin(pin), .o_flow_dp(flow_dp), .o_flow_valid(flow_valid), .o_alarm(alarm));
	slg_meter u_slg_meter (.i_clk(clk), .o_pin(pin));

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic int rnd(input int m);
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return int'(rng % m);
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	// Holds the request until pready is sampled high, then lets one edge pass idle.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk(32'h0000_0000, 32'h0000_0001, "no pready");
		@(posedge clk);
	endtask

	task automatic wait_valid;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (flow_valid !== 1'b1 && n < 100);
		if (n >= 100)
			chk(32'h0000_0000, 32'h0000_0001, "no datapoint");
	endtask

	task automatic count_dp(input int len, input int gap, output int n);
		n = 0;
		repeat (len) begin
			@(posedge clk);
			if (flow_valid === 1'b1) begin
				n++;
				chk(32'(flow_dp.net), 32'h0000_0000, "fill net");
				chk(32'(flow_dp.long_iv), 32'(gap), "fill gap");
				chk(32'(flow_dp.short_iv), 32'(gap), "fill min max");
			end
		end
	endtask

	task automatic end_sim;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// --------------------------------------------------------------
	// Clock and watchdog
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		$display("unexpected at %0t: watchdog ran out", $time);
		end_sim();
	end

	// --------------------------------------------------------------
	// Main sequence
	// --------------------------------------------------------------
	initial begin
		int r, n0, n1, k, g;
		realtime t0;
		rng = 32'd65361;
		fails = 0;
		checks = 0;
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);

		apb(1'b0, `SLG_A_CTRL, 32'h0000_0000);
		chk(q, `SLG_RST_CTRL, "ctrl reset");
		apb(1'b0, `SLG_A_PERIOD, 32'h0000_0000);
		chk(q, 32'(`SLG_RST_PERIOD), "period reset");
		apb(1'b0, `SLG_A_THR, 32'h0000_0000);
		chk(q, `SLG_RST_THR, "thr reset");
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk({q[30:0], e}, 32'h0000_0001, "unmapped read");
		apb(1'b1, `SLG_A_NET, 32'hFFFF_FFFF);
		apb(1'b0, `SLG_A_NET, 32'h0000_0000);
		chk(q, 32'h0000_0000, "read-only write");

		// Both pins as status, channel 1 inverted, rising alarms on both.
		apb(1'b1, `SLG_A_PERIOD, 32'h0000_0001);
		apb(1'b1, `SLG_A_CTRL, 32'h0000_0E31);
		for (int i = 0; i < 4; i++) begin
			r = rnd(4);
			u_slg_meter.set_lvl(r[1:0]);
			repeat (25) @(posedge clk);
			apb(1'b0, `SLG_A_SDP, 32'h0000_0000);
			chk(q, {15'h0000, ~r[1], 15'h0000, r[0]}, "level dp");
			chk(32'(alarm), 32'({~r[1], r[0]}), "rising alarm");
			apb(1'b0, `SLG_A_STAT, 32'h0000_0000);
			chk(32'(q[3:0]), 32'({~r[1], r[0], r[1:0]}), "raw pins");
		end
		apb(1'b0, `SLG_A_NET, 32'h0000_0000);
		chk(q, 32'h0000_0000, "status pins kept out of flow");

		apb(1'b1, `SLG_A_THR, 32'h0001_0001);
		apb(1'b1, `SLG_A_CTRL, 32'h0000_0031);
		u_slg_meter.set_lvl(2'b01);
		repeat (25) @(posedge clk);
		chk(32'(alarm), 32'h0000_0000, "above one never fires");

		// Time-on, channel 1 inverted; thresholds sit on the period boundary values.
		apb(1'b1, `SLG_A_PERIOD, 32'h0000_0003);
		apb(1'b1, `SLG_A_THR, 32'h0003_0002);
		apb(1'b1, `SLG_A_CTRL, 32'h0000_0371);
		for (int i = 0; i < 2; i++) begin
			u_slg_meter.set_lvl(i ? 2'b00 : 2'b11);
			repeat (70) @(posedge clk);
			apb(1'b0, `SLG_A_SDP, 32'h0000_0000);
			chk(q, {16'(3 * i), 16'(3 * (1 - i))}, "time on");
			chk(32'(alarm), 32'(1 - i), "time on threshold");
		end

		// Forward and reverse pulse counts, separate pins.
		apb(1'b1, `SLG_A_CTRL, 32'h0000_0001);
		apb(1'b1, `SLG_A_PERIOD, 32'h0000_0002);
		wait_valid();
		for (int i = 0; i < 3; i++) begin
			n0 = rnd(4);
			n1 = rnd(4);
			exp_q.push_back(n0 - n1);
			fork
				repeat (n0) u_slg_meter.pulse(0, 4);
				repeat (n1) u_slg_meter.pulse(1, 4);
			join
			wait_valid();
			chk(32'(flow_dp.net), 32'(exp_q.pop_front()), "net count");
		end

		// Combined mode: pin 1 held high marks every pin 0 pulse as reverse flow.
		apb(1'b1, `SLG_A_CTRL, 32'h0000_0003);
		u_slg_meter.set_lvl(2'b10);
		@(posedge clk);
		n0 = 1 + rnd(3);
		repeat (n0) u_slg_meter.pulse(0, 4);
		wait_valid();
		chk(32'(flow_dp.net), 32'(-n0), "combined net");
		u_slg_meter.set_lvl(2'b00);

		// Event, minimum and maximum interval modes with four pulses a period.
		for (int m = 1; m < 4; m++) begin
			apb(1'b1, `SLG_A_CTRL, 32'(1 + 4 * m));
			g = 2 + rnd(3);
			u_slg_meter.pulse(0, 3);
			u_slg_meter.pulse(0, g);
			u_slg_meter.pulse(0, 3);
			t0 = $realtime;
			u_slg_meter.pulse(0, 2);
			wait_valid();
			chk(32'(flow_dp.net), 32'h0000_0004, "interval count");
			chk(32'(flow_dp.short_iv), 32'(g < 3 ? g : 3), "shortest gap");
			chk(32'(flow_dp.long_iv > 24'h00_0004), 32'h0000_0001, "longest gap");
		end

		// Quiet periods, then one pulse backfills every skipped datapoint.
		k = 1 + rnd(3);
		count_dp(20 * k + 4, 0, n0);
		chk(32'(n0), 32'h0000_0000, "no datapoint while waiting");
		g = int'(($realtime - t0) / 25.0);
		u_slg_meter.pulse(0, 2);
		count_dp(10, g, n1);
		chk(32'(n1), 32'(k), "backfill count");
		end_sim();
	end
endmodule
